// ==== bench/rtp_core_checker.sv ====
// Checker: port-level properties of the parameter service
`timescale 1ns/1ps
module rtp_core_checker
  import rtp_pkg::*;
#(
  parameter int NODES = 32
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fb_wr,
  input wire logic [15:0] fb_index,
  input wire logic [7:0] fb_subindex,
  input wire logic fb_refused,
  input wire logic test_mode,
  input wire logic param_revert,
  input wire logic isl_req,
  input wire logic isl_write,
  input wire logic [7:0] isl_node,
  input wire logic [15:0] isl_index,
  input wire logic [2:0] isl_length,
  input wire logic isl_revert,
  input wire logic [1:0] node_state,
  input wire logic [NODES-1:0] hotswap_set,
  input wire logic [NODES-1:0] hotswap_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  req_spacing_a: assert property (isl_req |=> !isl_req [*3])
    else $error("island requests too close");
  write_state_a: assert property (isl_req && isl_write |-> node_state == NODE_ST_OP)
    else $error("write to node not operational");
  write_range_a: assert property (isl_req && isl_write |->
    isl_index >= INDEX_MIN_WRITE && isl_node inside {[NODE_MIN:NODE_MAX]})
    else $error("write index or node out of range");
  read_range_a: assert property (isl_req |->
    isl_index >= INDEX_MIN_READ && isl_length inside {[3'h1:3'h4]})
    else $error("access index or length out of range");
  revert_pass_a: assert property (isl_revert == param_revert)
    else $error("revert not passed on");
  fb_test_a: assert property (fb_wr && test_mode |-> fb_refused)
    else $error("fieldbus write taken in test mode");
  fb_rsp_a: assert property (fb_wr && fb_index == OBJ_RESPONSE |-> fb_refused)
    else $error("response object written");
  fb_req_a: assert property (fb_wr && !test_mode && fb_index == OBJ_REQUEST &&
    fb_subindex inside {[8'h01:OBJ_REQ_SUB_MAX]} |-> !fb_refused)
    else $error("request object write refused");
  swap_set_a: assert property (|hotswap_set |=>
    (hotswap_flag & $past(hotswap_set)) == $past(hotswap_set))
    else $error("hot-swap flag not set");
  cover property (isl_req && isl_write);
  cover property (isl_req && !isl_write);
  cover property (fb_wr && fb_refused);
endmodule
bind rtp_core rtp_core_checker #(.NODES(NODES)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .fb_wr(fb_wr), .fb_index(fb_index), .fb_subindex(fb_subindex), .fb_refused(fb_refused),
  .test_mode(test_mode), .param_revert(param_revert), .isl_req(isl_req),
  .isl_write(isl_write), .isl_node(isl_node), .isl_index(isl_index),
  .isl_length(isl_length), .isl_revert(isl_revert), .node_state(node_state),
  .hotswap_set(hotswap_set), .hotswap_flag(hotswap_flag));

// ==== bench/rtp_island_model.sv ====
// Island access responder, prompt or slow
`timescale 1ns/1ps
module rtp_island_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic [7:0] fail_code,
  input wire logic isl_req,
  input wire logic [15:0] isl_index,
  input wire logic [7:0] isl_subindex,
  output logic isl_done,
  output logic [7:0] isl_status,
  output logic [31:0] isl_rdata
);
  logic [3:0] wait_r;
  logic busy_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      isl_done <= 1'b0;
      isl_status <= 8'h00;
      isl_rdata <= 32'h0000_0000;
    end else begin
      isl_done <= 1'b0;
      isl_status <= ~isl_status;
      isl_rdata <= ~isl_rdata;
      if (isl_req) begin
        busy_r <= 1'b1;
        wait_r <= slow ? 4'h9 : 4'h0;
      end else if (busy_r && wait_r != 4'h0) begin
        wait_r <= wait_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        isl_done <= 1'b1;
        isl_status <= fail_code;
        isl_rdata <= {isl_index, 8'h00, isl_subindex};
      end
    end
  end
endmodule

// ==== bench/runtime_param_request_handshake_tb.sv ====
// Testbench: random and corner requests over both register paths
`timescale 1ns/1ps
module runtime_param_request_handshake_tb;
  import rtp_pkg::*;
  logic sys_clk, reset, mb_wr, fb_wr, test_mode, rtp_configured, param_revert, slow;
  logic [15:0] mb_addr, mb_wdata, fb_index, fb_wdata, mb_rdata, fb_rdata, isl_index;
  logic [7:0] fb_subindex, fail_code, isl_node, isl_subindex, isl_status;
  logic [31:0] isl_wdata, isl_rdata, lfsr, hotswap_set, hotswap_flag;
  logic [2:0] isl_length;
  logic [1:0] node_state;
  logic fb_refused, isl_req, isl_write, isl_revert, isl_done, tog, en_m, clk_en;
  int err_total, n_tests, n_req;
  rtp_core u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .mb_wr(mb_wr),
    .mb_addr(mb_addr), .mb_wdata(mb_wdata), .mb_rdata(mb_rdata), .fb_wr(fb_wr),
    .fb_index(fb_index), .fb_subindex(fb_subindex), .fb_wdata(fb_wdata),
    .fb_rdata(fb_rdata), .fb_refused(fb_refused), .test_mode(test_mode),
    .rtp_configured(rtp_configured), .param_revert(param_revert), .isl_req(isl_req),
    .isl_write(isl_write), .isl_node(isl_node), .isl_index(isl_index),
    .isl_subindex(isl_subindex), .isl_length(isl_length), .isl_wdata(isl_wdata),
    .isl_revert(isl_revert), .isl_done(isl_done), .isl_status(isl_status),
    .isl_rdata(isl_rdata), .node_state(node_state), .hotswap_set(hotswap_set),
    .hotswap_flag(hotswap_flag));
  rtp_island_model u_isl (.sys_clk(sys_clk), .reset(reset), .slow(slow),
    .fail_code(fail_code), .isl_req(isl_req), .isl_index(isl_index),
    .isl_subindex(isl_subindex), .isl_done(isl_done), .isl_status(isl_status),
    .isl_rdata(isl_rdata));
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(string w, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_st(logic [6:0] c, logic [7:0] n, logic [6:0] l,
      logic [15:0] ix);
    if (!(c inside {CMD_READ, CMD_WRITE, CMD_ENABLE, CMD_DISABLE, CMD_HOTSWAP_CLR}))
      return {en_m, ST_ILL_CMD};
    if (!((n >= NODE_MIN && n <= NODE_MAX) || n == NODE_SELF)) return {en_m, ST_ILL_NODE};
    if (!en_m && c != CMD_ENABLE) return ST_SKIPPED;
    if (c == CMD_ENABLE) return rtp_configured ? 8'h80 : {en_m, ST_GENERAL};
    if (c == CMD_DISABLE) return 8'h00;
    if (c == CMD_HOTSWAP_CLR) return 8'h80;
    if (l < LEN_MIN || l > LEN_MAX) return {1'b1, ST_ILL_LEN};
    if (c == CMD_WRITE && n == NODE_SELF) return {1'b1, ST_WR_SELF};
    if (ix < (c == CMD_WRITE ? INDEX_MIN_WRITE : INDEX_MIN_READ)) return 8'h86;
    if (n != NODE_SELF && node_state != NODE_ST_OP &&
        (c == CMD_WRITE || node_state != NODE_ST_PREOP)) return 8'h85;
    if (fail_code == 8'h00) return 8'h80;
    return {1'b1, fail_code[6:0]};
  endfunction
  task automatic rd(logic [15:0] a, output logic [15:0] v);
    @(negedge sys_clk);
    mb_addr = a;
    #1 v = mb_rdata;
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(negedge sys_clk);
    mb_wr = test_mode;
    fb_wr = !test_mode;
    {mb_addr, mb_wdata, fb_wdata} = {a, d, d};
    fb_subindex = 8'(a - ADDR_REQ_HEADER + 16'h0001);
    @(negedge sys_clk);
    {mb_wr, fb_wr} = 2'h0;
  endtask
  task automatic req(logic [6:0] c, logic [7:0] n, logic [6:0] l, logic [15:0] ix,
      logic [31:0] d);
    logic [15:0] s, e, lo, hi;
    logic [7:0] st;
    tog = !tog;
    st = exp_st(c, n, l, ix);
    wr(ADDR_REQ_INDEX, ix);
    wr(ADDR_REQ_DATA_LO, d[15:0]);
    wr(ADDR_REQ_DATA_HI, d[31:16]);
    wr(ADDR_REQ_COMMAND, {tog, c, n});
    wr(ADDR_REQ_HEADER, {8'h00, tog, l});
    @(negedge sys_clk);
    clk_en = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(ADDR_RSP_ECHO, e);
    check("frozen echo", e[7:0] === {tog, c}, 1'b0);
    @(negedge sys_clk);
    clk_en = 1'b1;
    for (int k = 0; k < 40 && (s[7:0] !== {tog, c} || e[7:0] !== {tog, c}); k++) begin
      rd(ADDR_RSP_STATUS, s);
      rd(ADDR_RSP_ECHO, e);
    end
    check("echo", {s[7:0], e[7:0]}, {tog, c, tog, c});
    check("status", s[15:8], st);
    if ((st == 8'h80 || st == 8'h90) && (c == CMD_READ || c == CMD_WRITE)) begin
      rd(ADDR_RSP_DATA_LO, lo);
      rd(ADDR_RSP_DATA_HI, hi);
      check("rdata", {hi, lo}, (c == CMD_READ || st == 8'h90) ? {ix, 16'h0000} : 32'h0);
    end
    en_m = (c == CMD_ENABLE && st == 8'h80) || (en_m && c != CMD_DISABLE);
  endtask
  always @(posedge sys_clk) if (isl_req) n_req++;
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    err_total++;
    test_done();
  end
  initial begin
    int f, k;
    logic [15:0] v;
    logic [6:0] c;
    {reset, mb_wr, fb_wr, param_revert, slow, tog, en_m, test_mode} = 8'h81;
    clk_en = 1'b1;
    {rtp_configured, mb_addr, mb_wdata, fb_wdata, fail_code, fb_subindex} = '0;
    {fb_index, node_state, hotswap_set, lfsr} = {OBJ_REQUEST, NODE_ST_OP, 64'h0F39};
    {err_total, n_tests, n_req} = '0;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    wr(ADDR_RSP_STATUS, 16'hFFFF);
    rd(ADDR_RSP_STATUS, v);
    check("ro status", v, RESET_WORD);
    req(CMD_READ, 8'h01, 7'h04, 16'h2000, 32'h0);
    req(CMD_ENABLE, NODE_SELF, 7'h01, 16'h0, 32'h0);
    rtp_configured = 1'b1;
    req(CMD_ENABLE, NODE_SELF, 7'h01, 16'h0, 32'h0);
    req(CMD_READ, 8'h00, 7'h01, 16'h1000, 32'h0);
    req(CMD_READ, 8'h20, 7'h01, 16'h1000, 32'h0);
    $display("test enable done");
    @(negedge sys_clk);
    hotswap_set = 32'h0000_0008;
    @(negedge sys_clk);
    hotswap_set = '0;
    req(CMD_HOTSWAP_CLR, 8'h04, 7'h01, 16'h0, 32'h0);
    check("swap clr", hotswap_flag, 32'h0);
    k = n_req;
    wr(ADDR_REQ_COMMAND, {tog, CMD_READ, 8'h01});
    repeat (8) @(negedge sys_clk);
    check("no rerun", n_req, k);
    {fb_wr, fb_subindex, fb_wdata} = {1'b1, 8'h05, ~tog, CMD_WRITE, 8'h02};
    #1 check("fb refused", fb_refused, 1'b1);
    @(negedge sys_clk);
    fb_wr = 1'b0;
    #1 check("fb req obj", fb_rdata, {tog, CMD_READ, 8'h01});
    {fb_index, fb_subindex} = {OBJ_RESPONSE, 8'h01};
    rd(ADDR_RSP_STATUS, v);
    check("fb rsp obj", fb_rdata, v);
    fb_index = OBJ_REQUEST;
    $display("test handshake done");
    for (int i = 0; i < 30; i++) begin
      lfsr = nx(lfsr);
      {test_mode, slow, param_revert} = lfsr[2:0];
      fail_code = lfsr[3] ? 8'h10 : 8'h00;
      f = lfsr[10:8] % 5;
      node_state = f == 0 ? lfsr[5:4] : NODE_ST_OP;
      c = f == 1 ? (lfsr[16] ? 7'h00 : lfsr[17] ? 7'h05 : 7'h0B) :
        (lfsr[11] ? CMD_WRITE : CMD_READ);
      req(c, f == 3 ? 8'h21 + {lfsr[14:12], 4'h0} : (lfsr[15] && f == 0) ? NODE_SELF :
        8'h01 + lfsr[20:16], f == 2 ? (lfsr[16] ? 7'h00 : 7'h05) : 7'h01 + lfsr[18:17],
        f == 4 ? (c == CMD_WRITE ? 16'h1FFF : 16'h0FFF) : (lfsr[21] ? 16'h2000 :
        lfsr[31:16] | 16'h2000), lfsr);
    end
    $display("test random done");
    req(CMD_DISABLE, NODE_SELF, 7'h01, 16'h0, 32'h0);
    req(CMD_READ, 8'h01, 7'h01, 16'h2000, 32'h0);
    $display("test disable done");
    test_done();
  end
endmodule

// ==== core/rtp_core.sv ====
// Run-time parameter request/response service with toggle handshake
// Contract
// - Service parameter changes revert on reset events
// - Test mode blocks fieldbus request writes
// - Test mode keeps words reachable via Modbus
// - Request is five words, fixed layout
// - Index range 0x2000 write, 0x1000 read
// - Length byte: toggle top, length 1..4
// - Nodes 1..32 or 127 only
// - Process only when both toggles match
// - Reprocess only after both toggles change
// - Request exposed as object 0x4101 sub 1..5
// - Response four read-only words, enable in status
// - Response exposed as object 0x4100 sub 1..4
// - Status and data written before echo bytes
// - Enable/disable node 127, hot-swap clear 1..32
// - Read from op/preop, write op only
// - One request at a time, others ignored
// - Hot-swap flag per module reported
// - Success 0x80 or 0x00, skipped 0x01
// - Error codes 0x82..0x89, 0x90, 0xFF; code gives 0x02, 0x04, 0x7F with top bit clear while not enabled
`timescale 1ns/1ps
module rtp_core
  import rtp_pkg::*;
#(
  parameter int NODES = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Modbus register port (configuration tool or operator panel)
  input wire logic mb_wr,
  input wire logic [15:0] mb_addr,
  input wire logic [15:0] mb_wdata,
  output logic [15:0] mb_rdata,
  // Fieldbus object port
  input wire logic fb_wr,
  input wire logic [15:0] fb_index,
  input wire logic [7:0] fb_subindex,
  input wire logic [15:0] fb_wdata,
  output logic [15:0] fb_rdata,
  output logic fb_refused,
  // Mode and configuration
  input wire logic test_mode,
  input wire logic rtp_configured,
  input wire logic param_revert,
  // Island parameter access
  output logic isl_req,
  output logic isl_write,
  output logic [7:0] isl_node,
  output logic [15:0] isl_index,
  output logic [7:0] isl_subindex,
  output logic [2:0] isl_length,
  output logic [31:0] isl_wdata,
  output logic isl_revert,
  input wire logic isl_done,
  input wire logic [7:0] isl_status,
  input wire logic [31:0] isl_rdata,
  input wire logic [1:0] node_state,
  // Hot-swap indication
  input wire logic [NODES-1:0] hotswap_set,
  output logic [NODES-1:0] hotswap_flag
);

  // ----------------------------------------
  // Request and response storage
  // ----------------------------------------
  logic [15:0] req_r [5];
  logic [15:0] rsp_r [4];
  logic enabled_r;
  logic [7:0] done_cmd_r;
  logic [7:0] done_len_r;
  rtp_state_t state_r;
  logic [7:0] status_r;
  logic [31:0] data_r;
  logic [NODES-1:0] hs_r;
  logic req_r_q;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire fb_req_obj = fb_index == OBJ_REQUEST;
  wire fb_rsp_obj = fb_index == OBJ_RESPONSE;
  wire fb_req_sub_ok = fb_subindex >= 8'h01 && fb_subindex <= OBJ_REQ_SUB_MAX;
  wire fb_rsp_sub_ok = fb_subindex >= 8'h01 && fb_subindex <= OBJ_RSP_SUB_MAX;
  wire [2:0] fb_req_sel = 3'(fb_subindex - 8'h01);
  wire [1:0] fb_rsp_sel = 2'(fb_subindex - 8'h01);
  wire fb_req_wr = fb_wr && fb_req_obj && fb_req_sub_ok && !test_mode;
  assign fb_refused = fb_wr && !(fb_req_obj && fb_req_sub_ok && !test_mode);
  wire mb_req_hit = mb_addr >= ADDR_REQ_HEADER && mb_addr <= ADDR_REQ_COMMAND;
  wire [2:0] mb_req_sel = 3'(mb_addr - ADDR_REQ_HEADER);
  wire mb_req_wr = mb_wr && mb_req_hit && test_mode;
  wire mb_rsp_hit = mb_addr >= ADDR_RSP_STATUS && mb_addr <= ADDR_RSP_ECHO;
  wire [1:0] mb_rsp_sel = 2'(mb_addr - ADDR_RSP_STATUS);

  // ----------------------------------------
  // Read paths
  // ----------------------------------------
  assign mb_rdata = mb_req_hit ? req_r[mb_req_sel] :
                    mb_rsp_hit ? rsp_r[mb_rsp_sel] : RESET_WORD;
  assign fb_rdata = (fb_req_obj && fb_req_sub_ok) ? req_r[fb_req_sel] :
                    (fb_rsp_obj && fb_rsp_sub_ok) ? rsp_r[fb_rsp_sel] : RESET_WORD;

  // ----------------------------------------
  // Request fields
  // ----------------------------------------
  wire [7:0] len_byte = req_r[0][7:0];
  wire [7:0] sub_idx = req_r[0][15:BYTE_HI_LSB];
  wire [15:0] index = req_r[1];
  wire [31:0] wdata = {req_r[3], req_r[2]};
  wire [7:0] cmd_byte = req_r[4][15:BYTE_HI_LSB];
  wire [7:0] node = req_r[4][7:0];
  wire [6:0] cmd = cmd_byte[6:0];
  wire [6:0] len = len_byte[6:0];
  wire tog_match = cmd_byte[TOGGLE_BIT] == len_byte[TOGGLE_BIT];
  wire tog_new = cmd_byte[TOGGLE_BIT] != done_cmd_r[TOGGLE_BIT] &&
                 len_byte[TOGGLE_BIT] != done_len_r[TOGGLE_BIT];
  wire start = state_r == RTP_IDLE && tog_match && tog_new;

  // ----------------------------------------
  // Field checks
  // ----------------------------------------
  wire node_io = node >= NODE_MIN && node <= NODE_MAX;
  wire node_ok = node_io || node == NODE_SELF;
  wire cmd_ok = cmd >= CMD_MIN && cmd <= CMD_MAX;
  wire is_rw = cmd == CMD_READ || cmd == CMD_WRITE;
  wire len_ok = !is_rw || (len >= LEN_MIN && len <= LEN_MAX);
  wire idx_ok = cmd == CMD_WRITE ? index >= INDEX_MIN_WRITE :
                cmd == CMD_READ ? index >= INDEX_MIN_READ : 1'b1;
  wire cmd_known = is_rw || cmd == CMD_ENABLE || cmd == CMD_DISABLE ||
                   cmd == CMD_HOTSWAP_CLR;
  wire node_cmd_ok = (cmd == CMD_READ) ? node_ok :
                     (cmd == CMD_WRITE) ? (node_io || node == NODE_SELF) :
                     (cmd == CMD_HOTSWAP_CLR) ? node_io : node == NODE_SELF;
  wire state_ok = cmd == CMD_READ ? (node == NODE_SELF || node_state == NODE_ST_OP ||
                                     node_state == NODE_ST_PREOP) :
                  cmd == CMD_WRITE ? node_state == NODE_ST_OP : 1'b1;
  wire [5:0] hs_sel = 6'(node - NODE_MIN);

  // Check result; error first, else zero meaning go ahead
  logic [7:0] chk_status;
  always_comb begin
    chk_status = 8'h00;
    if (!cmd_ok || !cmd_known) chk_status = {enabled_r, ST_ILL_CMD};
    else if (!node_ok) chk_status = {enabled_r, ST_ILL_NODE};
    else if (!enabled_r && cmd != CMD_ENABLE) chk_status = ST_SKIPPED;
    else if (!len_ok) chk_status = {enabled_r, ST_ILL_LEN};
    else if (cmd == CMD_WRITE && node == NODE_SELF) chk_status = {enabled_r, ST_WR_SELF};
    else if (!node_cmd_ok) chk_status = {enabled_r, ST_ILL_NODE};
    else if (!idx_ok) chk_status = {enabled_r, ST_ILL_INDEX};
    else if (!state_ok) chk_status = {enabled_r, ST_ILL_STATE};
    else if (cmd == CMD_ENABLE && !rtp_configured) chk_status = {enabled_r, ST_GENERAL};
  end

  // ----------------------------------------
  // Island access outputs
  // ----------------------------------------
  assign isl_req = req_r_q;
  assign isl_write = cmd == CMD_WRITE;
  assign isl_node = node;
  assign isl_index = index;
  assign isl_subindex = sub_idx;
  assign isl_length = 3'(len);
  assign isl_wdata = wdata;
  assign isl_revert = param_revert;
  assign hotswap_flag = hs_r;

  // ----------------------------------------
  // Request words
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 5; i++) req_r[i] <= RESET_WORD;
    end else if (clk_en) begin
      if (fb_req_wr) req_r[fb_req_sel] <= fb_wdata;
      else if (mb_req_wr) req_r[mb_req_sel] <= mb_wdata;
    end
  end

  // ----------------------------------------
  // Hot-swap flags, set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hs_r <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < NODES; i++) begin
        if (hotswap_set[i]) hs_r[i] <= 1'b1;
        else if (state_r == RTP_STATUS && cmd == CMD_HOTSWAP_CLR &&
                 status_r[6:0] == ST_SUCCESS && hs_sel == 6'(i)) hs_r[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= RTP_IDLE;
      enabled_r <= 1'b0;
      done_cmd_r <= 8'h00;
      done_len_r <= 8'h00;
      status_r <= 8'h00;
      data_r <= '0;
      req_r_q <= 1'b0;
      for (int i = 0; i < 4; i++) rsp_r[i] <= RESET_WORD;
    end else if (clk_en) begin
      req_r_q <= 1'b0;
      unique case (state_r)
        RTP_IDLE: begin
          if (start) begin
            done_cmd_r <= cmd_byte;
            done_len_r <= len_byte;
            state_r <= RTP_CHECK;
          end
        end
        RTP_CHECK: begin
          data_r <= '0;
          if (chk_status != 8'h00) begin
            status_r <= chk_status;
            state_r <= RTP_STATUS;
          end else if (is_rw) begin
            req_r_q <= 1'b1;
            state_r <= RTP_ACCESS;
          end else begin
            if (cmd == CMD_ENABLE) enabled_r <= 1'b1;
            if (cmd == CMD_DISABLE) enabled_r <= 1'b0;
            status_r <= {cmd != CMD_DISABLE, ST_SUCCESS};
            state_r <= RTP_STATUS;
          end
        end
        RTP_ACCESS: begin
          if (isl_done) begin
            status_r <= isl_status == 8'h00 ? {1'b1, ST_SUCCESS} :
                        {1'b1, isl_status[6:0]};
            data_r <= cmd == CMD_READ || isl_status[6:0] == ST_ABORT ? isl_rdata : '0;
            state_r <= RTP_STATUS;
          end
        end
        RTP_STATUS: begin
          rsp_r[0][15:BYTE_HI_LSB] <= status_r;
          rsp_r[1] <= data_r[15:0];
          rsp_r[2] <= data_r[31:16];
          state_r <= RTP_ECHO;
        end
        RTP_ECHO: begin
          rsp_r[0][7:0] <= done_cmd_r;
          rsp_r[3] <= {8'h00, done_cmd_r};
          state_r <= RTP_IDLE;
        end
        default: state_r <= RTP_IDLE;
      endcase
    end
  end

endmodule

// ==== core/rtp_pkg.sv ====
// Package: register map, field layout, codes and states of the run-time parameter service
package rtp_pkg;
  // Request block word addresses
  localparam logic [15:0] ADDR_REQ_HEADER = 16'hB04A;
  localparam logic [15:0] ADDR_REQ_INDEX = 16'hB04B;
  localparam logic [15:0] ADDR_REQ_DATA_LO = 16'hB04C;
  localparam logic [15:0] ADDR_REQ_DATA_HI = 16'hB04D;
  localparam logic [15:0] ADDR_REQ_COMMAND = 16'hB04E;
  // Response block word addresses
  localparam logic [15:0] ADDR_RSP_STATUS = 16'hB0F7;
  localparam logic [15:0] ADDR_RSP_DATA_LO = 16'hB0F8;
  localparam logic [15:0] ADDR_RSP_DATA_HI = 16'hB0F9;
  localparam logic [15:0] ADDR_RSP_ECHO = 16'hB0FA;
  // Fieldbus object indices
  localparam logic [15:0] OBJ_REQUEST = 16'h4101;
  localparam logic [15:0] OBJ_RESPONSE = 16'h4100;
  localparam logic [7:0] OBJ_REQ_SUB_MAX = 8'h05;
  localparam logic [7:0] OBJ_RSP_SUB_MAX = 8'h04;
  // Field positions
  localparam int TOGGLE_BIT = 7;
  localparam int BYTE_HI_LSB = 8;
  // Reset values
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Range limits
  localparam logic [15:0] INDEX_MIN_WRITE = 16'h2000;
  localparam logic [15:0] INDEX_MIN_READ = 16'h1000;
  localparam logic [6:0] LEN_MIN = 7'h01;
  localparam logic [6:0] LEN_MAX = 7'h04;
  localparam logic [6:0] CMD_MIN = 7'h01;
  localparam logic [6:0] CMD_MAX = 7'h0A;
  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'h20;
  localparam logic [7:0] NODE_SELF = 8'h7F;
  // Command codes
  localparam logic [6:0] CMD_READ = 7'h01;
  localparam logic [6:0] CMD_WRITE = 7'h02;
  localparam logic [6:0] CMD_ENABLE = 7'h08;
  localparam logic [6:0] CMD_DISABLE = 7'h09;
  localparam logic [6:0] CMD_HOTSWAP_CLR = 7'h0A;
  // Status codes
  localparam logic [6:0] ST_SUCCESS = 7'h00;
  localparam logic [7:0] ST_SKIPPED = 8'h01;
  localparam logic [6:0] ST_ILL_CMD = 7'h02;
  localparam logic [6:0] ST_ILL_LEN = 7'h03;
  localparam logic [6:0] ST_ILL_NODE = 7'h04;
  localparam logic [6:0] ST_ILL_STATE = 7'h05;
  localparam logic [6:0] ST_ILL_INDEX = 7'h06;
  localparam logic [6:0] ST_OVERSIZE = 7'h07;
  localparam logic [6:0] ST_NO_BUS = 7'h08;
  localparam logic [6:0] ST_WR_SELF = 7'h09;
  localparam logic [6:0] ST_ABORT = 7'h10;
  localparam logic [6:0] ST_GENERAL = 7'h7F;
  // Node states reported by the island side
  localparam logic [1:0] NODE_ST_PREOP = 2'h1;
  localparam logic [1:0] NODE_ST_OP = 2'h2;
  // Controller states, Gray along idle-check-access-status-echo
  typedef enum logic [2:0] {
    RTP_IDLE = 3'b000,
    RTP_CHECK = 3'b001,
    RTP_ACCESS = 3'b011,
    RTP_STATUS = 3'b010,
    RTP_ECHO = 3'b110
  } rtp_state_t;
endpackage
